// ===== shared/sync_div_pkg.sv
// Constants for the sync clock divider pair
// Assumes both ends share SYS_CLK as the sync clock
`default_nettype none
package sync_div_pkg;
  // Register indices as printed, byte address is four times the index
  localparam logic [31:0] DIV_CTRL_INDEX    = 32'h0000_4E48;
  localparam logic [31:0] START_DELAY_INDEX = 32'h0004_80C6;
  localparam logic [31:0] DIV_CTRL_ADDR     = 32'h0001_3920;
  localparam logic [31:0] START_DELAY_ADDR  = 32'h0012_0318;
  // Controller registers on APB
  localparam logic [11:0] CMD_DIV_OFS       = 12'h000;
  localparam logic [11:0] CMD_GO_OFS        = 12'h004;
  localparam logic [11:0] STAT_OFS          = 12'h008;
  localparam logic [11:0] RDATA_OFS         = 12'h00C;
  localparam int          STAT_BUSY_BIT     = 0;
  localparam int          STAT_REJ_BIT      = 1;
  localparam int          GO_WRITE_BIT      = 0;
  localparam int          GO_RDDIV_BIT      = 1;
  localparam int          GO_RDDLY_BIT      = 2;
  localparam logic [15:0] DIV_RESET         = 16'h0001;
  localparam logic [15:0] DIV_MAX           = 16'h07D0;
  localparam int          NUM_DIVS          = 17;
  localparam logic [15:0] DIV_SET [NUM_DIVS] = '{
    16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h000A, 16'h0010, 16'h0014, 16'h0028, 16'h0032,
    16'h0050, 16'h0064, 16'h00C8, 16'h0190, 16'h01F4, 16'h0320, 16'h03E8, 16'h07D0};
  // Start delay: fixed base plus BOARD_DELAY plus divider share, in samples
  localparam logic [31:0] DELAY_BASE        = 32'h0000_0004;
  localparam logic [2:0]  MAX_ACT_CH        = 3'h4;

  function automatic logic div_legal(input logic [31:0] v);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < NUM_DIVS; i++) begin
      if (v == {16'h0000, DIV_SET[i]}) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction
endpackage
`default_nettype wire

// ===== shared/sync_div_if.sv
// Register port between a board controller and a board's divider block
// Assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface sync_div_if (input wire logic clk);
  logic        req;
  logic        wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        ack;
  logic        err;
  logic [31:0] rdata;
  modport dev  (input req, wr, addr, wdata, output ack, err, rdata);
  modport ctrl (output req, wr, addr, wdata, input ack, err, rdata);
endinterface
`default_nettype wire

// ===== design/sync_div_dev.sv
// Board end: extra clock divider, sample clock enable and start delay
// Assumes sync clock is SYS_CLK; request held until ack
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Software programs divider on every synced board
// - Divider register readable and writable
// - Only listed divider values are accepted
// - Fastest same-type board is master, divider one
// - Sample clock is sync clock over divider
// - Channel rate is divided clock over channels
// - Highest sum rate board becomes clock master
// - Non FIFO offset fixed by setup
// - Software compensates single shot generation offset
// - FIFO start offset from type, divider, channels
// - Read-only start delay in samples
// - Offset is master delay minus slave delay
module sync_div_dev (
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  sync_div_if.dev         BUS,
  input  wire logic [2:0] ACT_CH,
  input  wire logic [7:0] BOARD_DELAY,
  output logic            SAMPLE_EN,
  output logic            CHAN_EN,
  output logic [15:0]     DIVIDER
);
  typedef struct packed {
    logic [15:0] div;
    logic [15:0] cnt;
    logic [2:0]  ch_cnt;
    logic        smp;
    logic        chan;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [2:0] ch_n;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    ch_n = (ACT_CH == 3'h0) ? 3'h1 : ((ACT_CH > sync_div_pkg::MAX_ACT_CH) ? sync_div_pkg::MAX_ACT_CH : ACT_CH);
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.smp = 1'b0;
    st_nxt.chan = 1'b0;
    // Divided sum clock, fixed phase for a given setup
    if (st_r.cnt >= st_r.div - 16'h0001) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.smp = 1'b1;
      // One conversion per ch_n sum samples, ch_n being ACT_CH limited to 1 to 4
      if (st_r.ch_cnt >= ch_n - 3'h1) begin
        st_nxt.ch_cnt = 3'h0;
        st_nxt.chan = 1'b1;
      end else begin
        st_nxt.ch_cnt = st_r.ch_cnt + 3'h1;
      end
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    if (BUS.req && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      if (BUS.addr == sync_div_pkg::DIV_CTRL_ADDR) begin
        if (BUS.wr) begin
          if (sync_div_pkg::div_legal(BUS.wdata)) begin
            st_nxt.div = BUS.wdata[15:0];
            st_nxt.cnt = 16'h0000;
            st_nxt.ch_cnt = 3'h0;
          end else begin
            st_nxt.err = 1'b1;
          end
        end else begin
          st_nxt.rdata = {16'h0000, st_r.div};
        end
      end else if (BUS.addr == sync_div_pkg::START_DELAY_ADDR && !BUS.wr) begin
        // Start delay grows with divider, shrinks with channels
        st_nxt.rdata = sync_div_pkg::DELAY_BASE + {24'h000000, BOARD_DELAY}
                       + {13'h0000, st_r.div, 3'h0} / {29'h00000000, ch_n};
      end else begin
        st_nxt.err = 1'b1;
        st_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r <= '{div: sync_div_pkg::DIV_RESET, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign BUS.ack   = st_r.ack;
  assign BUS.err   = st_r.err;
  assign BUS.rdata = st_r.rdata;
  assign SAMPLE_EN = st_r.smp;
  assign CHAN_EN   = st_r.chan;
  assign DIVIDER   = st_r.div;
endmodule
`default_nettype wire

// ===== design/sync_div_ctrl.sv
// Controller end: APB slave that forwards divider and delay accesses
// Assumes the board end acks one cycle after a held request
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sync_div_ctrl (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic [31:0]      PRDATA,
  sync_div_if.ctrl         BUS
);
  typedef enum logic [1:0] {IDLE = 2'b00, REQ = 2'b01, WAIT = 2'b11} phase_e;
  typedef struct packed {
    phase_e      ph;
    logic [31:0] cmd_div;
    logic        rej;
    logic [31:0] rd;
    logic        wr;
    logic [31:0] addr;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic   access;

  // ----------------------------------------
  // APB and link sequencing
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    access = PSEL && PENABLE;
    PREADY = 1'b1;
    PSLVERR = 1'b0;
    PRDATA = 32'h0000_0000;
    unique case (PADDR)
      sync_div_pkg::CMD_DIV_OFS: PRDATA = st_r.cmd_div;
      sync_div_pkg::STAT_OFS:    PRDATA = {30'h00000000, st_r.rej, st_r.ph != IDLE};
      sync_div_pkg::RDATA_OFS:   PRDATA = st_r.rd;
      sync_div_pkg::CMD_GO_OFS:  PRDATA = 32'h0000_0000;
      default:                   PSLVERR = access;
    endcase
    if (access && PWRITE) begin
      if (PADDR == sync_div_pkg::CMD_DIV_OFS) begin
        st_nxt.cmd_div = PWDATA;
      end else if (PADDR == sync_div_pkg::CMD_GO_OFS && st_r.ph == IDLE) begin
        // Divider writes go only to the board
        if (PWDATA[sync_div_pkg::GO_WRITE_BIT]) begin
          st_nxt.ph = REQ;
          st_nxt.wr = 1'b1;
          st_nxt.addr = sync_div_pkg::DIV_CTRL_ADDR;
        end else if (PWDATA[sync_div_pkg::GO_RDDIV_BIT]) begin
          st_nxt.ph = REQ;
          st_nxt.wr = 1'b0;
          st_nxt.addr = sync_div_pkg::DIV_CTRL_ADDR;
        end else if (PWDATA[sync_div_pkg::GO_RDDLY_BIT]) begin
          // Delay feeds software offset arithmetic
          st_nxt.ph = REQ;
          st_nxt.wr = 1'b0;
          st_nxt.addr = sync_div_pkg::START_DELAY_ADDR;
        end
      end
    end
    unique case (st_r.ph)
      IDLE: ;
      REQ:  st_nxt.ph = WAIT;
      WAIT: begin
        if (BUS.ack) begin
          st_nxt.ph = IDLE;
          st_nxt.rej = BUS.err;
          st_nxt.rd = BUS.rdata;
        end
      end
      default: st_nxt.ph = IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r <= '{ph: IDLE, cmd_div: {16'h0000, sync_div_pkg::DIV_RESET}, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Divider passed on as written; board end vets it
  assign BUS.req   = st_r.ph != IDLE;
  assign BUS.wr    = st_r.wr;
  assign BUS.addr  = st_r.addr;
  assign BUS.wdata = st_r.cmd_div;
endmodule
`default_nettype wire

// ===== verification/sync_div_sva.sv
// Assertions on the link between controller and board end
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sync_div_sva (
  input wire logic        clk,
  input wire logic        RST,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic        err,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (RST);
  logic to_div;
  logic legal;
  assign to_div = addr == sync_div_pkg::DIV_CTRL_ADDR;
  assign legal  = wdata[31:16] == 16'h0000 && (wdata[15:0] inside {sync_div_pkg::DIV_SET});
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  a_ack_answers: assert property ($rose(req) |=> ack) else $error("ack late");
  a_req_holds: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
    else $error("request not held");
  a_req_drops: assert property (ack |=> !req) else $error("request kept after ack");
  a_err_with_ack: assert property (err |-> ack) else $error("err without ack");
  a_bad_div: assert property ($rose(req) && wr && to_div && !legal |=> err)
    else $error("illegal divider taken");
  a_good_div: assert property ($rose(req) && wr && to_div && legal |=> !err)
    else $error("legal divider refused");
  a_dly_read: assert property ($rose(req) && !wr && addr == sync_div_pkg::START_DELAY_ADDR |=> !err)
    else $error("start delay read refused");
  a_rdata_hold: assert property (!ack ##1 !ack |-> $stable(rdata)) else $error("rdata moved");
  c_bad: cover property ($rose(req) && wr && to_div && !legal);
  c_dly: cover property (ack && !wr && addr == sync_div_pkg::START_DELAY_ADDR);
  c_wr: cover property (ack && wr && !err);
endmodule
`default_nettype wire

// ===== verification/sync_clock_divider_tb_top.sv
// Testbench joining controller and board end over the link
// Assumes APB answers per note; register map from the package
`timescale 1ns/1ps
`default_nettype none
module sync_clock_divider_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        perr;
  logic        sample_en;
  logic        chan_en;
  logic [2:0]  act_ch = 3'h1;
  logic [15:0] divider;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          ns;
  int          nc;
  logic [31:0] slv_dly;
  always #50 clk = ~clk;
  sync_div_if u_if (.clk(clk));
  sync_div_dev u_sync_div_dev (.SYS_CLK(clk), .RST(rst), .BUS(u_if), .ACT_CH(act_ch), .BOARD_DELAY(8'h05),
    .SAMPLE_EN(sample_en), .CHAN_EN(chan_en), .DIVIDER(divider));
  sync_div_ctrl u_sync_div_ctrl (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata), .BUS(u_if));
  sync_div_sva u_sva (.clk(clk), .RST(rst), .req(u_if.req), .wr(u_if.wr), .addr(u_if.addr),
    .wdata(u_if.wdata), .ack(u_if.ack), .err(u_if.err), .rdata(u_if.rdata));
  task automatic results();
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [31:0] cmd);
    apb(1'b1, sync_div_pkg::CMD_GO_OFS, cmd);
    for (int k = 0; k < 20; k++) begin
      apb(1'b0, sync_div_pkg::STAT_OFS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask
  task automatic wdiv(input logic [31:0] v, input logic [15:0] exp, input logic rej);
    apb(1'b1, sync_div_pkg::CMD_DIV_OFS, v);
    go(32'h1);
    chk({31'h0, rd[1]}, {31'h0, rej});
    chk({16'h0, divider}, {16'h0, exp});
    go(32'h2);
    apb(1'b0, sync_div_pkg::RDATA_OFS, 32'h0);
    chk(rd, {16'h0, exp});
  endtask
  task automatic dly(input logic [2:0] ch, input logic [31:0] exp);
    act_ch <= ch;
    go(32'h4);
    apb(1'b0, sync_div_pkg::RDATA_OFS, 32'h0);
    chk(rd, exp);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({16'h0, divider}, 32'h1);
    for (int i = 0; i < sync_div_pkg::NUM_DIVS; i++) begin
      wdiv({16'h0, sync_div_pkg::DIV_SET[i]}, sync_div_pkg::DIV_SET[i], 1'b0);
    end
    wdiv(32'h3, 16'h07D0, 1'b1);
    wdiv(32'h0, 16'h07D0, 1'b1);
    wdiv(32'h0001_0001, 16'h07D0, 1'b1);
    wdiv(32'hA, 16'h000A, 1'b0);
    dly(3'h2, 32'h0000_0031);
    slv_dly = rd;
    dly(3'h0, 32'h0000_0059);
    dly(3'h7, 32'h0000_001D);
    // Several GO bits: divider read wins over delay read
    go(32'h6);
    apb(1'b0, sync_div_pkg::RDATA_OFS, 32'h0);
    chk(rd, 32'h0000_000A);
    apb(1'b0, sync_div_pkg::CMD_DIV_OFS, 32'h0);
    chk(rd, 32'h0000_000A);
    act_ch <= 3'h2;
    repeat (40) @(posedge clk);
    ns = 0;
    nc = 0;
    repeat (100) begin
      @(posedge clk);
      ns += int'(sample_en === 1'b1);
      nc += int'(chan_en === 1'b1);
    end
    chk(ns, 32'h0000_000A);
    chk(nc, 32'h0000_0005);
    apb(1'b1, 12'h010, 32'h0);
    chk({31'h0, perr}, 32'h1);
    // Same board as clock master: divider one, offset against slave
    wdiv(32'h1, 16'h0001, 1'b0);
    dly(3'h4, 32'h0000_000B);
    chk(rd - slv_dly, 32'hFFFF_FFDA);
    results();
  end
endmodule
`default_nettype wire
